// ---- core/irq_mask_cfg.svh ----
// Offsets, field positions and reset values of the interrupt enable mask
`ifndef IRQ_MASK_CFG_SVH
`define IRQ_MASK_CFG_SVH
`define IRQ_MASK_OFFSET 8'h10
`define IRQ_MASK_RESET 32'h0000_0000
`define IRQ_MASK_WRITABLE 32'hc000_007f
`define IRQ_GLOBAL_BIT 31
`define IRQ_OWNER_BIT 30
`define IRQ_SRC_COUNT 9
`define IRQ_LOW_SRC_COUNT 7
`endif

// ---- core/irq_mask_pkg.sv ----
// Types shared by the interrupt enable mask modules
package irq_mask_pkg;
  typedef logic [31:0] word_type;
  typedef logic [7:0] offset_type;
  typedef logic [8:0] event_vec_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } bus_state_type;
endpackage

// ---- core/irq_mask_if.sv ----
// Carrier between the mask register file and its gating stage
interface irq_mask_if;
  import irq_mask_pkg::*;
  word_type mask;
  event_vec_type events;
  logic irq;
  modport regs (output mask, output events, input irq);
  modport gate (input mask, input events, output irq);
endinterface

// ---- core/irq_gate.sv ----
// Gating stage: per-source and global enables onto one registered interrupt
`include "irq_mask_cfg.svh"
module irq_gate (
  input wire logic ref_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  irq_mask_if.gate link // Mask and events in, interrupt out
);
  import irq_mask_pkg::*;

  event_vec_type enabled;
  logic irq_q;

  // --------------------------------------------------
  // Per-source enables
  // --------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `IRQ_LOW_SRC_COUNT; i++)
    begin : g_low
      // Sources 6..0 keep their own bit position in the mask
      assign enabled[i] = link.events[i] & link.mask[i];
    end
  endgenerate
  assign enabled[7] = link.events[7] & link.mask[`IRQ_OWNER_BIT];
  assign enabled[8] = 1'b0;

  // --------------------------------------------------
  // Global gate
  // --------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      irq_q <= 1'b0;
    else
      irq_q <= link.mask[`IRQ_GLOBAL_BIT] & (|enabled);
  end
  assign link.irq = irq_q;

  a_irq_needs_global: assert property (@(posedge ref_clk) disable iff (reset)
    link.irq |-> $past(link.mask[`IRQ_GLOBAL_BIT]))
    else $error("interrupt without global enable");
  a_irq_follows_src: assert property (@(posedge ref_clk) disable iff (reset)
    (link.mask[`IRQ_GLOBAL_BIT] && (|(link.events[6:0] & link.mask[6:0]))) |=> link.irq)
    else $error("enabled event did not raise interrupt");
  a_owner_gate: assert property (@(posedge ref_clk) disable iff (reset)
    (link.mask[31:30] == 2'b11 && link.events[7]) |=> link.irq)
    else $error("ownership change not raised");
  a_irq_cause: assert property (@(posedge ref_clk) disable iff (reset)
    link.irq |-> $past((|(link.events[6:0] & link.mask[6:0]))
      || (link.events[7] && link.mask[`IRQ_OWNER_BIT])))
    else $error("interrupt without enabled source");
endmodule

// ---- core/irq_mask.sv ----
// Interrupt enable mask register with global enable and registered interrupt
//
// Operation
// - Mask register sits at offset 10h of the operational register space.
// - No interrupt is raised unless global enable bit 31 is one.
// - Bit 30 enables ownership change events.
// - Bit 6 enables root hub status change events.
// - Bit 5 enables frame number overflow events.
// - Bit 4 enables unrecoverable error events.
// - Bit 3 enables resume detect events.
// - Bit 2 enables start-of-frame events.
// - Bit 1 enables done-list head writeback events.
// - Bit 0 enables scheduling overrun events.
`include "irq_mask_cfg.svh"
module irq_mask (
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic reg_sel, // Register access strobe, one cycle
  input wire logic reg_write, // 1 write, 0 read
  input wire irq_mask_pkg::offset_type reg_offset, // Offset within operational space
  input wire irq_mask_pkg::word_type reg_wdata, // Write data
  input wire logic disable_sel, // Clear strobe from the paired disable register
  input wire irq_mask_pkg::word_type disable_bits, // Bits to clear with disable_sel
  input wire logic [7:0] event_status, // Status: [7] owner change, [6:0] low sources
  output logic reg_ack, // Access answered, one cycle
  output irq_mask_pkg::word_type reg_rdata, // Read data, valid with reg_ack
  output logic irq_out, // Registered interrupt request
  output irq_mask_pkg::word_type mask_out // Current mask, registered
);
  import irq_mask_pkg::*;

  // Writable bits as a constant so the per-bit loop can index it
  localparam word_type WRITABLE = `IRQ_MASK_WRITABLE;

  word_type mask_q;
  word_type mask_d;
  word_type set_bits;
  word_type clear_bits;
  word_type rdata_q;
  word_type rdata_d;
  bus_state_type bus_state_q;
  bus_state_type bus_state_d;
  logic hit;
  logic write_hit;
  logic read_hit;
  irq_mask_if link ();

  // --------------------------------------------------
  // Register decode
  // --------------------------------------------------
  assign hit = reg_sel && (reg_offset == `IRQ_MASK_OFFSET);
  assign write_hit = hit && reg_write;
  assign read_hit = hit && !reg_write;

  // --------------------------------------------------
  // Mask bits
  // --------------------------------------------------
  // Reserved bits never store a one, so a careless write leaves no dead enable
  // A clear from the paired disable register wins over a set in the same cycle
  genvar b;
  generate
    for (b = 0; b < 32; b++)
    begin : g_bit
      assign set_bits[b] = write_hit && reg_wdata[b] && WRITABLE[b];
      assign clear_bits[b] = disable_sel && disable_bits[b];
      assign mask_d[b] = clear_bits[b] ? 1'b0 : (mask_q[b] | set_bits[b]);
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      mask_q <= `IRQ_MASK_RESET;
    else
      mask_q <= mask_d;
  end

  // --------------------------------------------------
  // Bus answer
  // --------------------------------------------------
  // Every strobe is answered one cycle later, so a master never hangs on an unmapped offset
  always_comb
  begin
    bus_state_d = ST_IDLE;
    case (bus_state_q)
      ST_IDLE:
        if (reg_sel)
          bus_state_d = ST_ACK;
      ST_ACK:
        if (reg_sel)
          bus_state_d = ST_ACK;
      default:
        bus_state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      bus_state_q <= ST_IDLE;
    else
      bus_state_q <= bus_state_d;
  end

  // Unmapped offsets and writes read back as zero
  assign rdata_d = read_hit ? mask_q : `IRQ_MASK_RESET;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rdata_q <= `IRQ_MASK_RESET;
    else
      rdata_q <= rdata_d;
  end

  // The answer strobe is the one-hot bit of the answer state, straight from its flop
  assign reg_ack = bus_state_q[1];
  assign reg_rdata = rdata_q;
  assign mask_out = mask_q;

  // --------------------------------------------------
  // Gating stage
  // --------------------------------------------------
  assign link.mask = mask_q;
  assign link.events = {1'b0, event_status};
  assign irq_out = link.irq;

  irq_gate u_gate (
    .ref_clk(ref_clk),
    .reset(reset),
    .link(link)
  );

  // --------------------------------------------------
  // Checks: mask register
  // --------------------------------------------------
  a_write_sets: assert property (@(posedge ref_clk) disable iff (reset)
    (write_hit && !disable_sel) |=>
      ((mask_q & $past(reg_wdata) & `IRQ_MASK_WRITABLE)
        == ($past(reg_wdata) & `IRQ_MASK_WRITABLE)))
    else $error("written one did not set mask bit");

  a_zero_keeps: assert property (@(posedge ref_clk) disable iff (reset)
    (!disable_sel) |=> ((mask_q & $past(mask_q)) == $past(mask_q)))
    else $error("mask bit lost without disable");

  a_mask_steady: assert property (@(posedge ref_clk) disable iff (reset)
    (!write_hit && !disable_sel) |=> (mask_q == $past(mask_q)))
    else $error("mask changed without access");

  a_clear_wins: assert property (@(posedge ref_clk) disable iff (reset)
    disable_sel |=> ((mask_q & $past(disable_bits)) == 32'h0000_0000))
    else $error("disabled bit still set");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
    mask_q[29:7] == 23'h00_0000)
    else $error("reserved mask bit set");

  a_global_writable: assert property (@(posedge ref_clk) disable iff (reset)
    (write_hit && reg_wdata[`IRQ_GLOBAL_BIT] && !disable_sel) |=> mask_q[`IRQ_GLOBAL_BIT])
    else $error("global enable not stored");

  a_owner_writable: assert property (@(posedge ref_clk) disable iff (reset)
    (write_hit && reg_wdata[`IRQ_OWNER_BIT] && !disable_sel) |=> mask_q[`IRQ_OWNER_BIT])
    else $error("ownership enable not stored");

  // --------------------------------------------------
  // Checks: bus answer
  // --------------------------------------------------
  a_read_mask: assert property (@(posedge ref_clk) disable iff (reset)
    read_hit |=> (reg_ack && reg_rdata == $past(mask_q)))
    else $error("read did not return mask");

  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_sel && !hit && !disable_sel) |=>
      (reg_ack && reg_rdata == `IRQ_MASK_RESET && mask_q == $past(mask_q)))
    else $error("unmapped access touched mask");

  a_ack_follows_sel: assert property (@(posedge ref_clk) disable iff (reset)
    reg_sel |=> reg_ack)
    else $error("access not answered");

  a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (reset)
    !reg_sel |=> (!reg_ack && reg_rdata == `IRQ_MASK_RESET))
    else $error("answer without access");

  a_state_onehot: assert property (@(posedge ref_clk) disable iff (reset)
    $onehot(bus_state_q))
    else $error("answer state not one-hot");

  // --------------------------------------------------
  // Checks: interrupt
  // --------------------------------------------------
  a_src_bit_gate: assert property (@(posedge ref_clk) disable iff (reset)
    (mask_q[`IRQ_GLOBAL_BIT] && mask_q[2] && event_status[2]) |=> irq_out)
    else $error("start-of-frame not raised");

  a_no_global: assert property (@(posedge ref_clk) disable iff (reset)
    !mask_q[`IRQ_GLOBAL_BIT] |=> !irq_out)
    else $error("interrupt with global enable clear");

  // Bit 2 has its own check above; the rest of the low sources share this one
  a_other_srcs: assert property (@(posedge ref_clk) disable iff (reset)
    (mask_q[`IRQ_GLOBAL_BIT] && |(mask_q[6:0] & event_status[6:0] & 7'h7b)) |=> irq_out)
    else $error("enabled source not raised");

  // --------------------------------------------------
  // Covers
  // --------------------------------------------------
  c_irq: cover property (@(posedge ref_clk) disable iff (reset) $rose(irq_out));
  c_write: cover property (@(posedge ref_clk) disable iff (reset) write_hit);
  c_read: cover property (@(posedge ref_clk) disable iff (reset) read_hit);
  c_owner: cover property (@(posedge ref_clk) disable iff (reset)
    mask_q[`IRQ_OWNER_BIT] && event_status[7]);
  c_clear_on_set: cover property (@(posedge ref_clk) disable iff (reset)
    write_hit && disable_sel);
endmodule

// ---- tb/testbench.sv ----
// Self-checking testbench for the interrupt enable mask register
`include "irq_mask_cfg.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_mask_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_sel = 1'b0;
  logic reg_write = 1'b0;
  offset_type reg_offset = 8'h00;
  word_type reg_wdata = 32'h0000_0000;
  logic disable_sel = 1'b0;
  word_type disable_bits = 32'h0000_0000;
  logic [7:0] event_status = 8'h00;
  logic reg_ack;
  logic irq_out;
  word_type reg_rdata;
  word_type mask_out;
  word_type rd;
  int n_errors = 0;
  int checks = 0;
  int src [8] = '{30, 6, 5, 4, 3, 2, 1, 0};
  always #5 ref_clk = ~ref_clk;
  irq_mask uut (.ref_clk(ref_clk), .reset(reset), .reg_sel(reg_sel), .reg_write(reg_write),
    .reg_offset(reg_offset), .reg_wdata(reg_wdata), .disable_sel(disable_sel),
    .disable_bits(disable_bits), .event_status(event_status), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .irq_out(irq_out), .mask_out(mask_out));
  task test_done();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Answer is fixed at one cycle, so a missing ack ends the run at once
  task access(input logic wr, input offset_type off, input word_type data);
    @(posedge ref_clk);
    reg_sel <= 1'b1;
    reg_write <= wr;
    reg_offset <= off;
    reg_wdata <= data;
    @(posedge ref_clk);
    reg_sel <= 1'b0;
    #1;
    if (reg_ack === 1'b1)
      rd = reg_rdata;
    else
    begin
      n_errors++;
      $display("BAD %0t no answer", $time);
      test_done();
    end
  endtask
  task clr(input word_type bits);
    @(posedge ref_clk);
    disable_sel <= 1'b1;
    disable_bits <= bits;
    @(posedge ref_clk);
    disable_sel <= 1'b0;
  endtask
  task events_to(input logic [7:0] st);
    @(posedge ref_clk);
    event_status <= st;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task t_reset();
    #1;
    `CHK(mask_out, `IRQ_MASK_RESET)
    access(1'b0, `IRQ_MASK_OFFSET, 32'h0000_0000);
    `CHK(rd, `IRQ_MASK_RESET)
    `CHK(irq_out, 1'b0)
    $display("t_reset done");
  endtask
  task t_write_set();
    access(1'b1, `IRQ_MASK_OFFSET, 32'h8000_0004);
    access(1'b1, `IRQ_MASK_OFFSET, 32'h0000_0002);
    access(1'b1, `IRQ_MASK_OFFSET, 32'h0000_0000);
    access(1'b0, `IRQ_MASK_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h8000_0006)
    access(1'b1, `IRQ_MASK_OFFSET, 32'hffff_ffff);
    `CHK(mask_out, `IRQ_MASK_WRITABLE)
    clr(32'hffff_ffff);
    access(1'b1, 8'h0c, 32'hffff_ffff);
    `CHK(mask_out, 32'h0000_0000)
    access(1'b0, 8'h0c, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    $display("t_write_set done");
  endtask
  // Each source alone: other statuses must not leak through its enable
  task t_sources();
    for (int k = 0; k < 8; k++)
    begin
      clr(32'hffff_ffff);
      access(1'b1, `IRQ_MASK_OFFSET, 32'h8000_0000 | (32'h0000_0001 << src[k]));
      events_to(~(8'h80 >> k));
      `CHK(irq_out, 1'b0)
      events_to(8'h80 >> k);
      `CHK(irq_out, 1'b1)
    end
    $display("t_sources done");
  endtask
  task t_global();
    clr(32'hffff_ffff);
    access(1'b1, `IRQ_MASK_OFFSET, 32'h0000_0004);
    events_to(8'h04);
    `CHK(irq_out, 1'b0)
    access(1'b1, `IRQ_MASK_OFFSET, 32'h8000_0000);
    events_to(8'h04);
    `CHK(irq_out, 1'b1)
    clr(32'h8000_0000);
    events_to(8'h04);
    `CHK(irq_out, 1'b0)
    `CHK(mask_out, 32'h0000_0004)
    $display("t_global done");
  endtask
  // Reset in mid-run with sources pending must drop mask and interrupt together
  task t_reset_again();
    access(1'b1, `IRQ_MASK_OFFSET, 32'hc000_007f);
    events_to(8'hff);
    `CHK(irq_out, 1'b1)
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    `CHK(mask_out, `IRQ_MASK_RESET)
    `CHK(irq_out, 1'b0)
    access(1'b0, `IRQ_MASK_OFFSET, 32'h0000_0000);
    `CHK(rd, `IRQ_MASK_RESET)
    events_to(8'h00);
    `CHK(irq_out, 1'b0)
    $display("t_reset_again done");
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_write_set();
    t_sources();
    t_global();
    t_reset_again();
    test_done();
  end
endmodule
